// >>> src/ecad_pkg.sv
package ecad_pkg;

	localparam int unsigned PC_W        = 12;
	localparam int unsigned STACK_CELLS = 6;
	localparam logic [7:0]  SHORT_BASE  = 8'h80;
	localparam logic [7:0]  PTR_X_ADDR  = 8'h80;
	localparam logic [7:0]  PTR_Y_ADDR  = 8'h81;
	localparam logic [11:0] PC_RESET    = 12'h000;
	localparam logic [7:0]  ACC_RESET   = 8'h00;

	// Opcode high nibbles of the non-relative groups
	localparam logic [3:0] GRP_INVOKE = 4'h8;
	localparam logic [3:0] GRP_GOTO   = 4'h9;
	localparam logic [3:0] GRP_BITDIR = 4'hA;
	localparam logic [3:0] GRP_BITTST = 4'hB;
	localparam logic [3:0] GRP_MOVE_0 = 4'hC;
	localparam logic [3:0] GRP_MOVE_1 = 4'hD;

	// Low nibbles inside the move groups
	localparam logic [3:0] LO_IND_LOAD  = 4'h8;
	localparam logic [3:0] LO_IND_STORE = 4'h9;
	localparam logic [3:0] LO_DIR_LOAD  = 4'hA;
	localparam logic [3:0] LO_DIR_STORE = 4'hB;
	localparam logic [3:0] LO_IMM_ACC   = 4'hC;
	localparam logic [3:0] LO_IMM_MEM   = 4'hD;
	localparam logic [3:0] LO_RETURN    = 4'hE;

	typedef enum logic [2:0] {
		ST_FETCH = 3'b000,
		ST_OPC   = 3'b001,
		ST_ARG1  = 3'b010,
		ST_ARG2  = 3'b011,
		ST_PTR   = 3'b100,
		ST_DRD   = 3'b101,
		ST_EXEC  = 3'b110
	} ecad_state_t;

	typedef enum logic [2:0] {
		TY_LOADSTORE = 3'b000,
		TY_ARITH     = 3'b001,
		TY_BRANCH    = 3'b010,
		TY_CONTROL   = 3'b011,
		TY_JUMPCALL  = 3'b100,
		TY_BITMANIP  = 3'b101
	} ecad_type_t;

	typedef enum logic [3:0] {
		AM_IMMEDIATE = 4'h0,
		AM_DIRECT    = 4'h1,
		AM_SHORT     = 4'h2,
		AM_EXTENDED  = 4'h3,
		AM_RELATIVE  = 4'h4,
		AM_BITDIRECT = 4'h5,
		AM_BITTEST   = 4'h6,
		AM_INDIRECT  = 4'h7,
		AM_INHERENT  = 4'h8
	} ecad_mode_t;

	typedef struct packed {
		logic        rd;
		logic [11:0] addr;
	} ecad_pm_req_t;

	typedef struct packed {
		logic       rd;
		logic       we;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ecad_ds_req_t;

	typedef struct packed {
		logic        valid;
		logic [7:0]  opcode;
		ecad_type_t  optype;
		ecad_mode_t  mode;
		logic [11:0] addr;
	} ecad_report_t;

endpackage

// >>> src/ecad_stack.sv
`timescale 1ns/1ps
`default_nettype none
module ecad_stack #(
	parameter int unsigned DEPTH = ecad_pkg::STACK_CELLS,
	parameter int unsigned WIDTH = ecad_pkg::PC_W
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic             push,
	input  wire logic             pop,
	input  wire logic [WIDTH-1:0] push_data,
	output logic      [WIDTH-1:0] top,
	output logic                  overflow
);
	logic [WIDTH-1:0] cell_q [DEPTH];
	logic [2:0]       ptr_q;
	logic [2:0]       depth_q;
	logic [2:0]       ptr_up;
	logic [2:0]       ptr_dn;

	// Circular index: a seventh nested call overwrites the oldest entry
	assign ptr_up = (ptr_q == 3'(DEPTH - 1)) ? 3'h0 : ptr_q + 3'h1;
	assign ptr_dn = (ptr_q == 3'h0) ? 3'(DEPTH - 1) : ptr_q - 3'h1;
	assign top    = cell_q[ptr_dn];

	// Return cells held apart from data space
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ptr_q    <= 3'h0;
			depth_q  <= 3'h0;
			overflow <= 1'b0;
			for (int i = 0; i < DEPTH; i++)
				cell_q[i] <= '0;
		end
		else if (push)
		begin
			cell_q[ptr_q] <= push_data;
			ptr_q         <= ptr_up;
			if (depth_q == 3'(DEPTH))
				overflow <= 1'b1;
			else
				depth_q <= depth_q + 3'h1;
		end
		else if (pop)
		begin
			ptr_q <= ptr_dn;
			if (depth_q != 3'h0)
				depth_q <= depth_q - 3'h1;
		end
	end
endmodule
`default_nettype wire

// >>> src/ecad_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module ecad_decoder (
	input  wire logic                  clk,
	input  wire logic                  resetn,
	input  wire logic [7:0]            pm_rdata,
	input  wire logic [7:0]            ds_rdata,
	output ecad_pkg::ecad_pm_req_t     pm_req,
	output ecad_pkg::ecad_ds_req_t     ds_req,
	output ecad_pkg::ecad_report_t     report,
	output logic [7:0]                 acc,
	output logic                       flag_c,
	output logic                       flag_z,
	output logic                       stack_ovf
);
	ecad_pkg::ecad_state_t  state_q, state_d;
	ecad_pkg::ecad_pm_req_t pm_d;
	ecad_pkg::ecad_ds_req_t ds_d;
	ecad_pkg::ecad_report_t rep_d;
	logic        wait_q, wait_d;
	logic [11:0] pc_q, pc_d;
	logic [11:0] ia_q, ia_d;
	logic [7:0]  ir_q, ir_d;
	logic [7:0]  arg1_q, arg1_d;
	logic [7:0]  arg2_q, arg2_d;
	logic [7:0]  dat_q, dat_d;
	logic [7:0]  acc_d;
	logic        c_d, z_d;
	logic        push, pop;
	logic [11:0] stack_top;
	logic        ovf_w;

	// Opcode under decode: live byte while capturing, held byte after
	logic [7:0] opc;
	logic [3:0] hi, lo;
	logic       is_rel, is_inv, is_goto, is_bitdir, is_bittst, is_move;
	logic       mv_short_ld, mv_short_st, mv_ind_ld, mv_ind_st;
	logic       mv_dir_ld, mv_dir_st, mv_imm_acc, mv_imm_mem, is_ret;
	logic       needs_arg1, needs_arg2, cond_true, bit_val;
	logic [7:0] ptr_addr, short_addr, bit_mask;
	logic [11:0] rel_dest, bt_dest, ext_dest;

	assign opc = (state_q == ecad_pkg::ST_OPC) ? pm_rdata : ir_q;
	assign hi  = opc[7:4];
	assign lo  = opc[3:0];

	// Group decode; top bit clear means relative branch
	assign is_rel    = ~opc[7];
	assign is_inv    = hi == ecad_pkg::GRP_INVOKE;
	assign is_goto   = hi == ecad_pkg::GRP_GOTO;
	assign is_bitdir = hi == ecad_pkg::GRP_BITDIR;
	assign is_bittst = hi == ecad_pkg::GRP_BITTST;
	assign is_move   = (hi == ecad_pkg::GRP_MOVE_0) || (hi == ecad_pkg::GRP_MOVE_1);

	// Move group split, accumulator on one side except for immediate-to-memory and return
	assign mv_short_ld = is_move && (lo[3:2] == 2'b00);
	assign mv_short_st = is_move && (lo[3:2] == 2'b01);
	assign mv_ind_ld   = is_move && (lo == ecad_pkg::LO_IND_LOAD);
	assign mv_ind_st   = is_move && (lo == ecad_pkg::LO_IND_STORE);
	assign mv_dir_ld   = is_move && (lo == ecad_pkg::LO_DIR_LOAD);
	assign mv_dir_st   = is_move && (lo == ecad_pkg::LO_DIR_STORE);
	assign mv_imm_acc  = is_move && (lo == ecad_pkg::LO_IMM_ACC);
	assign mv_imm_mem  = is_move && (lo == ecad_pkg::LO_IMM_MEM);
	assign is_ret      = is_move && (lo == ecad_pkg::LO_RETURN);

	// Inherent and short forms fetch nothing past the opcode
	assign needs_arg1 = is_inv | is_goto | is_bitdir | is_bittst
		| mv_dir_ld | mv_dir_st | mv_imm_acc | mv_imm_mem;
	assign needs_arg2 = is_bittst | mv_imm_mem;

	// Pointer chosen by opcode bit 4
	assign ptr_addr   = opc[4] ? ecad_pkg::PTR_Y_ADDR : ecad_pkg::PTR_X_ADDR;
	// Scratch register index carried in opcode
	assign short_addr = ecad_pkg::SHORT_BASE | {6'h00, lo[1:0]};
	assign bit_mask   = 8'h01 << opc[2:0];
	assign bit_val    = dat_q[opc[2:0]];

	// Branch condition: 00 nonzero, 01 no carry, 10 zero, 11 carry
	assign cond_true = opc[5] ? (opc[6] ? flag_c : ~flag_c)
		: (opc[6] ? flag_z : ~flag_z);

	// Forward 1..16 past own address, backward 0..15 before
	assign rel_dest = opc[4] ? ia_q - {8'h00, lo} : ia_q + {8'h00, lo} + 12'h001;
	// Signed third byte measured from own address plus one
	assign bt_dest  = ia_q + {{4{arg2_q[7]}}, arg2_q} + 12'h001;
	// Low opcode nibble is the upper part of the target
	assign ext_dest = {ir_q[3:0], arg1_q};

	function automatic ecad_pkg::ecad_type_t op_type(input logic [7:0] o);
		if (!o[7] || o[7:4] == ecad_pkg::GRP_BITTST)
			op_type = ecad_pkg::TY_BRANCH;
		else if (o[7:4] == ecad_pkg::GRP_INVOKE || o[7:4] == ecad_pkg::GRP_GOTO)
			op_type = ecad_pkg::TY_JUMPCALL;
		else if (o[7:4] == ecad_pkg::GRP_BITDIR)
			op_type = ecad_pkg::TY_BITMANIP;
		else if (o[7:5] == 3'b110 && o[3:0] < ecad_pkg::LO_RETURN)
			op_type = ecad_pkg::TY_LOADSTORE;
		else if (o[7:5] == 3'b110)
			op_type = ecad_pkg::TY_CONTROL;
		else
			op_type = ecad_pkg::TY_ARITH;
	endfunction

	function automatic ecad_pkg::ecad_mode_t op_mode(input logic [7:0] o);
		if (!o[7])
			op_mode = ecad_pkg::AM_RELATIVE;
		else if (o[7:5] == 3'b100)
			op_mode = ecad_pkg::AM_EXTENDED;
		else if (o[7:4] == ecad_pkg::GRP_BITDIR)
			op_mode = ecad_pkg::AM_BITDIRECT;
		else if (o[7:4] == ecad_pkg::GRP_BITTST)
			op_mode = ecad_pkg::AM_BITTEST;
		else if (o[7:5] != 3'b110)
			op_mode = ecad_pkg::AM_INHERENT;
		else if (o[3] == 1'b0)
			op_mode = ecad_pkg::AM_SHORT;
		else if (o[3:1] == 3'b100)
			op_mode = ecad_pkg::AM_INDIRECT;
		else if (o[3:1] == 3'b101)
			op_mode = ecad_pkg::AM_DIRECT;
		else if (o[3:1] == 3'b110)
			op_mode = ecad_pkg::AM_IMMEDIATE;
		else
			op_mode = ecad_pkg::AM_INHERENT;
	endfunction

	// Sequencer: every strobe lasts one cycle, data sampled the cycle after
	always_comb
	begin
		state_d = state_q;
		wait_d  = 1'b0;
		pm_d    = '0;
		pm_d.addr = pm_req.addr;
		ds_d    = '0;
		ds_d.addr = ds_req.addr;
		rep_d   = '0;
		pc_d    = pc_q;
		ia_d    = ia_q;
		ir_d    = ir_q;
		arg1_d  = arg1_q;
		arg2_d  = arg2_q;
		dat_d   = dat_q;
		acc_d   = acc;
		c_d     = flag_c;
		z_d     = flag_z;
		push    = 1'b0;
		pop     = 1'b0;
		if (!wait_q)
		begin
			unique case (state_q)
				ecad_pkg::ST_FETCH:
				begin
					pm_d.rd   = 1'b1;
					pm_d.addr = pc_q;
					ia_d      = pc_q;
					pc_d      = pc_q + 12'h001;
					wait_d    = 1'b1;
					state_d   = ecad_pkg::ST_OPC;
				end
				ecad_pkg::ST_OPC:
				begin
					ir_d = pm_rdata;
					if (needs_arg1)
					begin
						// Operand or address byte follows opcode
						pm_d.rd   = 1'b1;
						pm_d.addr = pc_q;
						pc_d      = pc_q + 12'h001;
						wait_d    = 1'b1;
						state_d   = ecad_pkg::ST_ARG1;
					end
					else if (mv_ind_ld | mv_ind_st)
					begin
						ds_d.rd   = 1'b1;
						ds_d.addr = ptr_addr;
						wait_d    = 1'b1;
						state_d   = ecad_pkg::ST_PTR;
					end
					else if (mv_short_ld)
					begin
						ds_d.rd   = 1'b1;
						ds_d.addr = short_addr;
						wait_d    = 1'b1;
						state_d   = ecad_pkg::ST_DRD;
					end
					else
						state_d = ecad_pkg::ST_EXEC;
				end
				ecad_pkg::ST_ARG1:
				begin
					arg1_d = pm_rdata;
					if (needs_arg2)
					begin
						// Third byte of the long forms
						pm_d.rd   = 1'b1;
						pm_d.addr = pc_q;
						pc_d      = pc_q + 12'h001;
						wait_d    = 1'b1;
						state_d   = ecad_pkg::ST_ARG2;
					end
					else if (is_bitdir | mv_dir_ld)
					begin
						ds_d.rd   = 1'b1;
						ds_d.addr = pm_rdata;
						wait_d    = 1'b1;
						state_d   = ecad_pkg::ST_DRD;
					end
					else
						state_d = ecad_pkg::ST_EXEC;
				end
				ecad_pkg::ST_ARG2:
				begin
					arg2_d = pm_rdata;
					if (is_bittst)
					begin
						ds_d.rd   = 1'b1;
						ds_d.addr = arg1_q;
						wait_d    = 1'b1;
						state_d   = ecad_pkg::ST_DRD;
					end
					else
						state_d = ecad_pkg::ST_EXEC;
				end
				ecad_pkg::ST_PTR:
				begin
					arg1_d = ds_rdata;
					if (mv_ind_ld)
					begin
						ds_d.rd   = 1'b1;
						ds_d.addr = ds_rdata;
						wait_d    = 1'b1;
						state_d   = ecad_pkg::ST_DRD;
					end
					else
						state_d = ecad_pkg::ST_EXEC;
				end
				ecad_pkg::ST_DRD:
				begin
					dat_d   = ds_rdata;
					state_d = ecad_pkg::ST_EXEC;
				end
				ecad_pkg::ST_EXEC:
				begin
					rep_d.valid  = 1'b1;
					rep_d.opcode = ir_q;
					rep_d.optype = op_type(ir_q);
					rep_d.mode   = op_mode(ir_q);
					rep_d.addr   = ia_q;
					state_d      = ecad_pkg::ST_FETCH;
					if (is_rel)
					begin
						// Untaken branch leaves pc on next instruction
						if (cond_true)
							pc_d = rel_dest;
					end
					else if (is_inv | is_goto)
					begin
						push = is_inv;
						pc_d = ext_dest;
					end
					else if (is_bitdir)
					begin
						// Read-modify-write touching only the chosen bit
						ds_d.we    = 1'b1;
						ds_d.addr  = arg1_q;
						ds_d.wdata = ir_q[3] ? (dat_q | bit_mask) : (dat_q & ~bit_mask);
					end
					else if (is_bittst)
					begin
						c_d = bit_val;
						if (bit_val == ir_q[3])
							pc_d = bt_dest;
					end
					else if (mv_short_ld | mv_ind_ld | mv_dir_ld)
					begin
						acc_d = dat_q;
						z_d   = dat_q == 8'h00;
					end
					else if (mv_short_st | mv_ind_st | mv_dir_st)
					begin
						ds_d.we    = 1'b1;
						ds_d.addr  = mv_short_st ? short_addr : arg1_q;
						ds_d.wdata = acc;
						z_d        = acc == 8'h00;
					end
					else if (mv_imm_acc)
					begin
						acc_d = arg1_q;
						z_d   = arg1_q == 8'h00;
					end
					else if (mv_imm_mem)
					begin
						// Constant to any data byte, flags untouched
						ds_d.we    = 1'b1;
						ds_d.addr  = arg1_q;
						ds_d.wdata = arg2_q;
					end
					else if (is_ret)
					begin
						pop  = 1'b1;
						pc_d = stack_top;
					end
				end
				default:
					state_d = ecad_pkg::ST_FETCH;
			endcase
		end
	end

	// State and outputs registered together
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_q <= ecad_pkg::ST_FETCH;
			wait_q  <= 1'b0;
			pm_req  <= '0;
			ds_req  <= '0;
			report  <= '0;
			pc_q    <= ecad_pkg::PC_RESET;
			ia_q    <= ecad_pkg::PC_RESET;
			ir_q    <= 8'h00;
			arg1_q  <= 8'h00;
			arg2_q  <= 8'h00;
			dat_q   <= 8'h00;
			acc     <= ecad_pkg::ACC_RESET;
			flag_c  <= 1'b0;
			flag_z  <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			wait_q  <= wait_d;
			pm_req  <= pm_d;
			ds_req  <= ds_d;
			report  <= rep_d;
			pc_q    <= pc_d;
			ia_q    <= ia_d;
			ir_q    <= ir_d;
			arg1_q  <= arg1_d;
			arg2_q  <= arg2_d;
			dat_q   <= dat_d;
			acc     <= acc_d;
			flag_c  <= c_d;
			flag_z  <= z_d;
		end
	end

	// Return address is the byte after the two-byte invoke
	ecad_stack u_stack (
		.clk       (clk),
		.resetn    (resetn),
		.push      (push),
		.pop       (pop),
		.push_data (pc_q),
		.top       (stack_top),
		.overflow  (ovf_w)
	);

	// Sticky overflow re-registered so the port comes from a flop
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			stack_ovf <= 1'b0;
		else
			stack_ovf <= ovf_w;
	end
endmodule
`default_nettype wire

// >>> dv/ecad_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ecad_checker (
	input wire logic                   clk,
	input wire logic                   resetn,
	input wire logic [7:0]             pm_rdata,
	input wire logic [7:0]             ds_rdata,
	input wire ecad_pkg::ecad_pm_req_t pm_req,
	input wire ecad_pkg::ecad_ds_req_t ds_req,
	input wire ecad_pkg::ecad_report_t report,
	input wire logic [7:0]             acc,
	input wire logic                   flag_c,
	input wire logic                   flag_z,
	input wire logic                   stack_ovf
);
	logic        pend_q;
	logic [11:0] own_q;
	// Own address of the running instruction, caught at its opcode fetch
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pend_q <= 1'b1;
			own_q  <= 12'h000;
		end
		else if (pm_req.rd && (pend_q || report.valid))
		begin
			pend_q <= 1'b0;
			own_q  <= pm_req.addr;
		end
		else if (report.valid)
			pend_q <= 1'b1;
	end
	// Expected fetch after a relative branch; flags are untouched by it
	wire logic        rel_take = (report.opcode[5] ? flag_c : flag_z) == report.opcode[6];
	wire logic [11:0] rel_span = {8'h00, report.opcode[3:0]};
	wire logic [11:0] rel_next = !rel_take ? own_q + 12'h001
		: (report.opcode[4] ? own_q - rel_span : own_q + 12'h001 + rel_span);
	logic [11:0] rel_q;
	// Target held past the pulse, since report fields clear once it ends
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			rel_q <= 12'h000;
		else if (report.valid)
			rel_q <= rel_next;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_fetch_at(logic [11:0] a);
		##[0:1] (pm_req.rd && pm_req.addr == a);
	endsequence
	a_rel_dest: assert property (
		report.valid && report.mode == ecad_pkg::AM_RELATIVE |=> s_fetch_at(rel_q))
		else $error("relative branch fetched wrong address");
	a_pm_spacing: assert property (pm_req.rd |=> !pm_req.rd)
		else $error("program reads back to back");
	a_ds_exclusive: assert property (!(ds_req.rd && ds_req.we))
		else $error("data read and write together");
	a_ds_spacing: assert property ((ds_req.rd || ds_req.we) |=> !(ds_req.rd || ds_req.we))
		else $error("data accesses back to back");
	a_rep_pulse: assert property (report.valid |=> !report.valid)
		else $error("report valid longer than one cycle");
	a_rep_idle: assert property (!report.valid |-> report.opcode == 8'h00 && report.addr == 12'h000)
		else $error("report fields not zero while idle");
	a_acc_cause: assert property (
		$changed(acc) |-> report.valid && flag_z == (acc == 8'h00))
		else $error("accumulator changed without retire or wrong zero flag");
	a_carry_cause: assert property (
		$changed(flag_c) |-> report.valid && report.mode == ecad_pkg::AM_BITTEST)
		else $error("carry changed outside a bit test");
	a_store_acc: assert property (
		ds_req.we && report.mode inside {ecad_pkg::AM_DIRECT, ecad_pkg::AM_INDIRECT,
		ecad_pkg::AM_SHORT} |-> ds_req.wdata == acc)
		else $error("store data is not the accumulator");
	a_ovf_sticky: assert property (stack_ovf |=> stack_ovf)
		else $error("stack overflow flag dropped");
endmodule
bind ecad_decoder ecad_checker u_ecad_checker (.clk(clk), .resetn(resetn), .pm_rdata(pm_rdata),
	.ds_rdata(ds_rdata), .pm_req(pm_req), .ds_req(ds_req), .report(report), .acc(acc),
	.flag_c(flag_c), .flag_z(flag_z), .stack_ovf(stack_ovf));
`default_nettype wire

// >>> dv/ecad_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ecad_mem_model (
	input  wire logic                   clk,
	input  wire ecad_pkg::ecad_pm_req_t pm_req,
	input  wire ecad_pkg::ecad_ds_req_t ds_req,
	output var logic [7:0]              pm_rdata,
	output var logic [7:0]              ds_rdata
);
	logic [7:0] pm [0:4095];
	logic [7:0] ds [0:255];
	initial
	begin
		pm_rdata = 8'h00;
		ds_rdata = 8'h00;
	end
	// Data valid for one cycle; inverted on each idle cycle after, so a stale byte shows again every other cycle
	always @(posedge clk)
	begin
		pm_rdata <= pm_req.rd ? pm[pm_req.addr] : ~pm_rdata;
		ds_rdata <= ds_req.rd ? ds[ds_req.addr] : ~ds_rdata;
		if (ds_req.we)
			ds[ds_req.addr] <= ds_req.wdata;
	end
endmodule
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic                   clk = 1'b0;
	logic                   resetn = 1'b0;
	int                     err_count = 0;
	int                     cmp_count = 0;
	logic [11:0]            nxt;
	logic [7:0]             pm_rdata;
	logic [7:0]             ds_rdata;
	logic [7:0]             acc;
	logic                   flag_c;
	logic                   flag_z;
	logic                   stack_ovf;
	ecad_pkg::ecad_pm_req_t pm_req;
	ecad_pkg::ecad_ds_req_t ds_req;
	ecad_pkg::ecad_report_t report;
	ecad_pkg::ecad_report_t rep;
	logic [7:0] prog [0:32] = '{8'hCC, 8'h00, 8'hCD, 8'h85, 8'hA5, 8'hCA, 8'h85, 8'hC1,
		8'hC6, 8'hD8, 8'hC9, 8'hCB, 8'h90, 8'hA8, 8'h90, 8'hA1, 8'h90, 8'hB8, 8'h90,
		8'h03, 8'hE0, 8'hB9, 8'h90, 8'h7F, 8'h22, 8'hE0, 8'hE0, 8'h75, 8'h41, 8'h01,
		8'hE0, 8'h9F, 8'hFE};
	always #5 clk = ~clk;
	ecad_decoder u_ecad_decoder (.clk(clk), .resetn(resetn), .pm_rdata(pm_rdata),
		.ds_rdata(ds_rdata), .pm_req(pm_req), .ds_req(ds_req), .report(report), .acc(acc),
		.flag_c(flag_c), .flag_z(flag_z), .stack_ovf(stack_ovf));
	ecad_mem_model u_ecad_mem_model (.clk(clk), .pm_req(pm_req), .ds_req(ds_req),
		.pm_rdata(pm_rdata), .ds_rdata(ds_rdata));
	task chk(input string what, input logic [11:0] exp, input logic [11:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Wait for one retire, then for the fetch that follows it
	task step(input logic [7:0] op);
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			#1;
			n++;
		end
		while (report.valid !== 1'b1 && n < 40);
		rep = report;
		chk("opcode", {4'h0, op}, {4'h0, report.opcode});
		n = 0;
		while (pm_req.rd !== 1'b1 && n < 3)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		nxt = pm_req.addr;
		@(posedge clk);
		#1;
	endtask
	function logic [11:0] dsb(input logic [7:0] a);
		return {4'h0, u_ecad_mem_model.ds[a]};
	endfunction
	task t_moves;
		step(8'hCC);
		chk("acc", 12'h000, {4'h0, acc});
		chk("mode", {8'h00, ecad_pkg::AM_IMMEDIATE}, {8'h00, rep.mode});
		chk("type", {9'h000, ecad_pkg::TY_LOADSTORE}, {9'h000, rep.optype});
		chk("zero", 12'h001, {11'h0, flag_z});
		step(8'hCD);
		chk("ds85", 12'h0A5, dsb(8'h85));
		chk("zero kept", 12'h001, {11'h0, flag_z});
		step(8'hCA);
		chk("acc", 12'h0A5, {4'h0, acc});
		step(8'hC1);
		chk("acc", 12'h03C, {4'h0, acc});
		chk("mode", {8'h00, ecad_pkg::AM_SHORT}, {8'h00, rep.mode});
		step(8'hC6);
		chk("ds82", 12'h03C, dsb(8'h82));
		step(8'hD8);
		chk("acc", 12'h05A, {4'h0, acc});
		step(8'hC9);
		chk("ds40", 12'h05A, dsb(8'h40));
		step(8'hCB);
		chk("ds90", 12'h05A, dsb(8'h90));
		$display("moves test done");
	endtask
	task t_bits;
		step(8'hA8);
		chk("ds90", 12'h05B, dsb(8'h90));
		step(8'hA1);
		chk("ds90", 12'h059, dsb(8'h90));
		step(8'hB8);
		chk("taken", 12'h015, nxt);
		chk("carry", 12'h001, {11'h0, flag_c});
		step(8'hB9);
		chk("not taken", 12'h018, nxt);
		chk("carry", 12'h000, {11'h0, flag_c});
		$display("bits test done");
	endtask
	task t_rel;
		step(8'h22);
		chk("fwd", 12'h01B, nxt);
		step(8'h75);
		chk("false", 12'h01C, nxt);
		step(8'h41);
		chk("false", 12'h01D, nxt);
		step(8'h01);
		chk("fwd", 12'h01F, nxt);
		$display("relative test done");
	endtask
	task t_far;
		step(8'h9F);
		chk("goto", 12'hFFE, nxt);
		step(8'h91);
		chk("goto", 12'h100, nxt);
		step(8'h14);
		chk("back", 12'h0FC, nxt);
		step(8'h82);
		chk("invoke", 12'h200, nxt);
		chk("type", {9'h000, ecad_pkg::TY_JUMPCALL}, {9'h000, rep.optype});
		step(8'hE5);
		chk("inherent", 12'h201, nxt);
		chk("own", 12'h200, rep.addr);
		step(8'hCE);
		chk("return", 12'h0FE, nxt);
		step(8'h93);
		$display("far test done");
	endtask
	task t_stack;
		for (int i = 0; i < 7; i++)
		begin
			step(8'h83);
			if (i == 5)
				chk("ovf early", 12'h000, {11'h0, stack_ovf});
		end
		@(posedge clk);
		#1;
		chk("ovf", 12'h001, {11'h0, stack_ovf});
		chk("chain", 12'h30E, nxt);
		$display("stack test done");
	endtask
	task put(input logic [11:0] a, input logic [7:0] b);
		u_ecad_mem_model.pm[a] = b;
	endtask
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		for (int i = 0; i < 33; i++)
			put(i[11:0], prog[i]);
		put(12'hFFE, 8'h91);
		put(12'hFFF, 8'h00);
		put(12'h100, 8'h14);
		put(12'h0FC, 8'h82);
		put(12'h0FD, 8'h00);
		put(12'h200, 8'hE5);
		put(12'h201, 8'hCE);
		put(12'h0FE, 8'h93);
		put(12'h0FF, 8'h00);
		put(12'h30E, 8'h93);
		put(12'h30F, 8'h0E);
		// Chain of invokes, each calling the next, to overfill the stack
		for (int i = 0; i < 7; i++)
		begin
			put(12'h300 + 12'(2 * i), 8'h83);
			put(12'h301 + 12'(2 * i), 8'h02 + 8'(2 * i));
		end
		u_ecad_mem_model.ds[8'h81] = 8'h3C;
		u_ecad_mem_model.ds[8'h3C] = 8'h5A;
		u_ecad_mem_model.ds[8'h80] = 8'h40;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		t_moves;
		t_bits;
		t_rel;
		t_far;
		t_stack;
		tally_and_finish;
	end
	// Whole program retires in well under a thousand cycles
	initial
	begin
		repeat (5000) @(posedge clk);
		err_count++;
		tally_and_finish;
	end
endmodule
`default_nettype wire
